/* common/flash_psp_pkg.sv */
package flash_psp_pkg;
  localparam logic [11:0] PAGE_SELECT_ADDR   = 12'hFF9;
  localparam logic [11:0] FLASH_CONTROL_ADDR = 12'hFF8;
  localparam logic [7:0]  PROTECT_UNLOCK     = 8'h5E;
  localparam logic [7:0]  PAGE_SELECT_RESET  = 8'h00;
  localparam logic [7:0]  PROTECT_RESET      = 8'h00;
  localparam int          WINDOW_BIT         = 7;
  localparam int          PAGE_MSB           = 6;
  localparam int          PAGE_ADDR_LSB      = 9;
  localparam int          PAGE_BYTES         = 512;
  localparam int          BIG_FLASH_BYTES    = 8192;
  localparam int          SMALL_FLASH_BYTES  = 4096;
  localparam int          SECTOR_COUNT       = 8;
  localparam logic [15:0] INFO_BASE          = 16'hFE00;
  localparam logic [7:0]  ERASED_BYTE        = 8'hFF;
  localparam logic [7:0]  PROGRAMMED_BYTE    = 8'h00;
  typedef enum logic [1:0] {OP_NONE, OP_PROGRAM, OP_ERASE} flash_op_t;

  // Sector index of a page number; big variant has two pages per sector
  function automatic logic [2:0] sector_of(input logic [6:0] page, input logic big);
    sector_of = big ? page[3:1] : page[2:0];
  endfunction
endpackage

/* src/flash_page_sector_protect.sv */
`timescale 1ns/1ps
module flash_page_sector_protect
  import flash_psp_pkg::*;
#(
  parameter logic BIG_VARIANT = 1'b1
)(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              srst,
  // Register file access
  input  wire logic [11:0]       reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  output logic                   reg_hit,
  // Flash operation request from the controller
  input  wire logic              op_req,
  input  wire flash_psp_pkg::flash_op_t op_kind,
  input  wire logic [8:0]        op_offset,
  input  wire logic [7:0]        op_data,
  input  wire logic              op_from_debugger,
  // Flash array side
  output logic                   arr_wr,
  output logic [15:0]            arr_addr,
  output logic [7:0]             arr_wdata,
  output logic                   arr_erase,
  output logic [6:0]             arr_erase_page,
  output logic                   arr_info_sel,
  output logic                   op_done,
  output logic                   op_abort,
  // State
  output logic [6:0]             page_number,
  output logic                   info_area_window_on,
  output logic [7:0]             sector_protect_bits
);
  import flash_psp_pkg::*;

  logic [7:0] flash_page_select;
  logic [7:0] flash_sector_protect;
  logic       protect_unlocked;
  logic       blocked;
  logic       hit_shared;
  logic       hit_control;

  assign hit_shared  = (reg_addr == PAGE_SELECT_ADDR);
  assign hit_control = (reg_addr == FLASH_CONTROL_ADDR);

  // Unlock follows the last control write; other values relock
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      protect_unlocked <= 1'b0;
    end else if (reg_wr && hit_control) begin
      protect_unlocked <= (reg_wdata == PROTECT_UNLOCK);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flash_page_select <= PAGE_SELECT_RESET;
    end else if (reg_wr && hit_shared && !protect_unlocked) begin
      flash_page_select <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flash_sector_protect <= PROTECT_RESET;
    end else if (reg_wr && hit_shared && protect_unlocked) begin
      flash_sector_protect <= flash_sector_protect | reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && hit_shared) begin
      reg_rdata <= protect_unlocked ? flash_sector_protect : flash_page_select;
    end
  end

  // Control register itself lives elsewhere; only the shared address is claimed
  assign reg_hit = (reg_rd || reg_wr) && hit_shared;

  assign page_number         = flash_page_select[PAGE_MSB:0];
  assign info_area_window_on = flash_page_select[WINDOW_BIT];
  assign sector_protect_bits = flash_sector_protect;

  flash_sector_guard u_guard (
    .page        (flash_page_select[PAGE_MSB:0]),
    .info_sel    (flash_page_select[WINDOW_BIT]),
    .big_variant (BIG_VARIANT),
    .protect     (flash_sector_protect),
    .blocked     (blocked)
  );

  // Address formation for program; info window sits at FE00H
  logic [15:0] target_addr;
  always_comb begin
    if (flash_page_select[WINDOW_BIT]) begin
      target_addr = INFO_BASE | {7'h00, op_offset};
    end else begin
      target_addr = {flash_page_select[PAGE_MSB:0], op_offset};
    end
  end

  logic refuse;
  assign refuse = blocked && !op_from_debugger;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      arr_wr         <= 1'b0;
      arr_erase      <= 1'b0;
      arr_addr       <= 16'h0000;
      arr_wdata      <= ERASED_BYTE;
      arr_erase_page <= 7'h00;
      arr_info_sel   <= 1'b0;
      op_done        <= 1'b0;
      op_abort       <= 1'b0;
    end else begin
      arr_wr    <= 1'b0;
      arr_erase <= 1'b0;
      op_done   <= 1'b0;
      op_abort  <= 1'b0;
      if (op_req && op_kind != OP_NONE) begin
        if (refuse) begin
          op_abort <= 1'b1;
        end else begin
          op_done      <= 1'b1;
          arr_info_sel <= flash_page_select[WINDOW_BIT];
          if (op_kind == OP_PROGRAM) begin
            arr_wr    <= 1'b1;
            arr_addr  <= target_addr;
            arr_wdata <= op_data;
          end else begin
            arr_erase      <= 1'b1;
            arr_erase_page <= flash_page_select[PAGE_MSB:0];
          end
        end
      end
    end
  end
endmodule

/* src/flash_sector_guard.sv */
`timescale 1ns/1ps
module flash_sector_guard
  import flash_psp_pkg::*;
(
  // Target
  input  wire logic [6:0] page,
  input  wire logic       info_sel,
  input  wire logic       big_variant,
  // Protection
  input  wire logic [7:0] protect,
  output logic            blocked
);
  logic out_of_range;
  always_comb begin
    // Pages beyond the array are refused as well
    out_of_range = big_variant ? (page > 7'd15) : (page > 7'd7);
    blocked = !info_sel && (out_of_range || protect[sector_of(page, big_variant)]);
  end
endmodule

/* test/flash_page_sector_protect_tb.sv */
`timescale 1ns/1ps
module flash_page_sector_protect_tb;
  import flash_psp_pkg::*;
  logic ref_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, op_req = 0, op_from_debugger = 0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00, op_data = 8'h00, reg_rdata, arr_wdata, sector_protect_bits;
  flash_op_t op_kind = OP_NONE;
  logic [8:0] op_offset = 9'h000;
  logic [15:0] arr_addr;
  logic [6:0] arr_erase_page, page_number;
  logic reg_hit, arr_wr, arr_erase, arr_info_sel, op_done, op_abort, info_area_window_on;
  int n_mismatch = 0, checks = 0, cycles = 0;
  always #5 ref_clk = ~ref_clk;
  flash_page_sector_protect flash_page_sector_protect_i (.*);
  task automatic report_and_stop;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
  endtask
  task automatic idle;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    op_req <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic rd(logic [11:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(negedge ref_clk);
    chk("hit", 16'h0001, {15'h0, reg_hit});
    idle();
  endtask
  task automatic op(flash_op_t k, logic [8:0] o);
    @(posedge ref_clk);
    op_req <= 1'b1;
    op_kind <= k;
    op_offset <= o;
    idle();
  endtask
  task automatic t_page;
    op(OP_PROGRAM, 9'h005);
    chk("prog", 16'h0002, {14'h0, op_done, op_abort});
    wr(12'hFF9, 8'h03);
    idle();
    op(OP_PROGRAM, 9'h005);
    chk("prog addr", 16'h0605, arr_addr);
    op(OP_ERASE, 9'h000);
    chk("erase", 16'h0183, {7'h00, arr_erase, op_done, arr_erase_page});
    wr(12'hFF9, 8'h0F);
    idle();
    op(OP_PROGRAM, 9'h1FF);
    chk("top addr", 16'h1FFF, arr_addr);
  endtask
  task automatic t_protect;
    wr(12'hFF8, 8'h5E);
    wr(12'hFF9, 8'h02);
    idle();
    chk("set", 16'h020F, {sector_protect_bits, info_area_window_on, page_number});
    wr(12'hFF8, 8'h5E);
    wr(12'hFF9, 8'h00);
    idle();
    chk("no clear", 16'h020F, {sector_protect_bits, info_area_window_on, page_number});
    wr(12'hFF8, 8'h00);
    wr(12'hFF9, 8'h82);
    idle();
    op(OP_PROGRAM, 9'h011);
    chk("info", 16'hFE11, arr_addr | {15'h0, ~arr_info_sel});
    wr(12'hFF9, 8'h02);
    idle();
    op(OP_ERASE, 9'h000);
    chk("guard", 16'h0001, {14'h0, arr_erase, op_abort});
  endtask
  task automatic t_access;
    rd(12'hFF9);
    chk("page read", 16'h0002, {8'h00, reg_rdata});
    wr(12'hFF8, 8'h5E);
    wr(12'hFF9, 8'h40);
    idle();
    rd(12'hFF9);
    chk("protect read", 16'h0042, {8'h00, reg_rdata});
    @(posedge ref_clk);
    op_from_debugger <= 1'b1;
    op_data <= 8'h00;
    op(OP_PROGRAM, 9'h004);
    chk("dbg addr", 16'h0404, arr_addr);
    chk("dbg data", 16'h0001, {arr_wdata, 7'h00, arr_wr});
    @(posedge ref_clk);
    op_from_debugger <= 1'b0;
    op(OP_PROGRAM, 9'h004);
    chk("user prog", 16'h0001, {14'h0, arr_wr, op_abort});
    wr(12'hFF8, 8'h00);
    wr(12'hFF9, 8'h10);
    idle();
    op(OP_ERASE, 9'h000);
    chk("range", 16'h0001, {14'h0, arr_erase, op_abort});
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    @(negedge ref_clk);
    chk("reset", 16'h0000, {sector_protect_bits, info_area_window_on, page_number});
    t_page();
    t_protect();
    t_access();
    report_and_stop();
  end
endmodule

/* test/flash_psp_props.sv */
`timescale 1ns/1ps
module flash_psp_props
  import flash_psp_pkg::*;
#(parameter logic BIG_VARIANT = 1'b1)(
  input wire logic ref_clk, srst, reg_wr, op_req, op_from_debugger, arr_wr, arr_erase, op_abort,
  input wire logic info_area_window_on,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata, sector_protect_bits,
  input wire flash_op_t op_kind,
  input wire logic [15:0] arr_addr,
  input wire logic [6:0] arr_erase_page, page_number
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire [2:0] sec = BIG_VARIANT ? page_number[3:1] : page_number[2:0];
  sequence s_key(logic ok); reg_wr && reg_addr == 12'hFF8 && (reg_wdata == 8'h5E) == ok; endsequence
  sequence s_shared; reg_wr && reg_addr == 12'hFF9; endsequence
  a_page_reset: assert property (disable iff (1'b0) srst |=> !info_area_window_on && page_number == 7'h00)
    else $error("page reset");
  a_locked_page: assert property (s_key(1'b0) ##1 s_shared |=>
    {1'b0, page_number} == ($past(reg_wdata) & 8'h7F) && $stable(sector_protect_bits)) else $error("locked write");
  a_unlocked_set: assert property (s_key(1'b1) ##1 s_shared |=>
    sector_protect_bits == ($past(sector_protect_bits) | $past(reg_wdata)) && $stable(page_number)) else $error("set");
  a_no_clear: assert property (($past(sector_protect_bits) & ~sector_protect_bits) == 8'h00)
    else $error("bit cleared");
  a_prog_page: assert property (op_req && op_kind == OP_PROGRAM && !info_area_window_on |=>
    op_abort || arr_wr && arr_addr[15:9] == $past(page_number)) else $error("prog page");
  a_erase_page: assert property (op_req && op_kind == OP_ERASE && !info_area_window_on |=>
    op_abort || arr_erase && arr_erase_page == $past(page_number)) else $error("erase page");
  a_info_map: assert property (op_req && op_kind == OP_PROGRAM && info_area_window_on |=>
    arr_wr && arr_addr[15:9] == 7'h7F) else $error("info map");
  a_guard_abort: assert property (op_req && op_kind != OP_NONE && !op_from_debugger && !info_area_window_on
    && sector_protect_bits[sec] |=> op_abort && !arr_wr && !arr_erase) else $error("guard");
endmodule
bind flash_page_sector_protect flash_psp_props #(.BIG_VARIANT(BIG_VARIANT)) props_i (.*);
